/* File: logic/cc_channel_defs.svh */
// Constants for the sixteen-channel capture and compare block
`ifndef CC_CHANNEL_DEFS_SVH
`define CC_CHANNEL_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CC_OFF_VALUE_BASE 8'h00
`define CC_OFF_VALUE_LAST 8'h3c
`define CC_OFF_MODE_LO    8'h40
`define CC_OFF_MODE_HI    8'h44
`define CC_OFF_LATCH      8'h48
`define CC_OFF_DIR        8'h4c
`define CC_OFF_FLAGS      8'h50
`define CC_OFF_STATUS     8'h54

// ****************************************************************
// Decoded register slots
// ****************************************************************
`define CC_SLOT_MODE_LO 5'h10
`define CC_SLOT_MODE_HI 5'h11
`define CC_SLOT_LATCH   5'h12
`define CC_SLOT_DIR     5'h13
`define CC_SLOT_FLAGS   5'h14
`define CC_SLOT_STATUS  5'h15
`define CC_SLOT_NONE    5'h1f

// ****************************************************************
// Channel mode field codes
// ****************************************************************
`define CC_MODE_OFF       3'h0
`define CC_MODE_CAP_RISE  3'h1
`define CC_MODE_CAP_FALL  3'h2
`define CC_MODE_CAP_BOTH  3'h3
`define CC_MODE_CMP_MULTI 3'h4
`define CC_MODE_CMP_TOGGLE 3'h5
`define CC_MODE_CMP_ONCE  3'h6
`define CC_MODE_CMP_SET   3'h7

// ****************************************************************
// Scan sequence and reset values
// ****************************************************************
`define CC_SCAN_FIRST  3'h0
`define CC_SCAN_LAST   3'h7
`define CC_RST_VALUE   16'h0000
`define CC_RST_MODE    3'h0
`define CC_RST_PORT    16'h0000
`define CC_RST_DONE    16'hffff

`endif

/* File: logic/cc_channel_pkg.sv */
// Types shared by the capture and compare block and its bench
`default_nettype none

package cc_channel_pkg;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // One free-running timer as seen by the channels
  typedef struct packed {
    logic [15:0] count;    // current count, already updated on inc/wr
    logic [15:0] reload;   // value loaded on overflow
    logic        inc;      // count advanced this cycle
    logic        ovf;      // count overflowed (and reloaded) this cycle
    logic        wr;       // software wrote the count this cycle
  } timer_t;

endpackage : cc_channel_pkg

`default_nettype wire

/* File: logic/capture_compare_channels.sv */
// Sixteen capture and compare channels with a sequential scan
//
// Operation
// R1: A capture copies the selected timer count into the channel value.
// R2: Mode field picks rising, falling or both edges as capture trigger.
// R3: Codes: 000 off/storage, 001 rising, 010 falling, 011 both edges.
// R4: Timer select 0 picks the first timer, 1 the second one.
// R5: Every capture also sets the channel request flag.
// R6: Software clears the direction bit so the pin is a capture input.
// R7: Capture inputs hold each level for at least 8 clock cycles.
// R8: Inputs scanned over 8 cycles; later slots see a changed timer.
// R9: With pin as output, a latch write can trigger a capture.
// R10: Compare modes match value to timer, set flag; 101 and 111 drive pin.
// R11: Equal values on several channels all fire within 8 cycles.
// R12: After a match, same value is blocked until timer inc or write.
// R13: Scan of 8 steps, 2 channels each; one event per value.
// R14: After reset no compare event until timer moves or is written.
// R15: Mode 100 flags every match; latch and pin untouched.
// R16: Mode 101 flags every match and inverts the output latch.
// R17: Toggle mode ignores timer overflow for pin and enabling.
// R18: Mode 110 flags first match per period only, until overflow.
// R19: Mode 111 sets latch on first match, clears it on overflow.
// R20: Mode 111 ignores a reloaded value until next period.
// R21: Mode 111 with value equal to reload flags but keeps the output.
// R22: Pin-driving modes need direction 1; latch writable any time.
// R23: Software latch write wins over a same-cycle hardware change.
// R24: Upper channel mode 100 with lower partner 101 signals pairing.
// R25: Request flag stays set until software or acknowledge clears it.
`default_nettype none

`include "cc_channel_defs.svh"

module capture_compare_channels (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // APB slave
  input  wire cc_channel_pkg::apb_req_t apbReq,
  output logic                          pready,
  output logic                          pslverr,
  output logic [31:0]                   prdata,
  // Timers
  input  wire cc_channel_pkg::timer_t   timerFirst,
  input  wire cc_channel_pkg::timer_t   timerSecond,
  // Channel pins
  input  wire logic [15:0]              pinIn,
  output logic [15:0]                   pinOut,
  output logic [15:0]                   pinOe,
  // Request flags
  input  wire logic [15:0]              flagAck,
  output logic [15:0]                   requestFlags,
  // Pairing enables, one per lower-bank channel
  output logic [7:0]                    pairedOp
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Word address to register slot; used by read and write paths
  function automatic logic [4:0] regSlot(input logic [7:0] a);
    logic [4:0] s;
    s = `CC_SLOT_NONE;
    if (a[1:0] == 2'h0) begin
      if (a <= `CC_OFF_VALUE_LAST) begin
        s = {1'b0, a[5:2]};
      end else begin
        case (a)
          `CC_OFF_MODE_LO: s = `CC_SLOT_MODE_LO;
          `CC_OFF_MODE_HI: s = `CC_SLOT_MODE_HI;
          `CC_OFF_LATCH:   s = `CC_SLOT_LATCH;
          `CC_OFF_DIR:     s = `CC_SLOT_DIR;
          `CC_OFF_FLAGS:   s = `CC_SLOT_FLAGS;
          `CC_OFF_STATUS:  s = `CC_SLOT_STATUS;
          default:         s = `CC_SLOT_NONE;
        endcase
      end
    end
    return s;
  endfunction : regSlot

  // Any of the four compare codes
  function automatic logic isCompare(input logic [2:0] m);
    return m[2];
  endfunction : isCompare

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0] valueR [16];
  logic [2:0]  modeR  [16];
  logic [15:0] selR;
  logic [15:0] latchR;
  logic [15:0] dirR;
  logic [15:0] flagR;
  logic [15:0] lastLvlR;
  logic [15:0] doneR;
  logic [15:0] periodDoneR;
  logic [2:0]  stepR;
  logic [31:0] prdataR;
  logic        pslverrR;

  logic [15:0] capEv;
  logic [15:0] cmpEv;
  logic [15:0] hwSet;
  logic [15:0] hwClr;
  logic [15:0] hwTog;
  logic [15:0] scanned;
  logic [15:0] curLvl;
  logic [15:0] fresh;
  logic [15:0] overflow;
  logic [15:0] capVal [16];

  logic        setupPh;
  logic        wrAcc;
  logic [4:0]  wrSlot;
  logic [4:0]  rdSlot;

  // ****************************************************************
  // APB decode
  // ****************************************************************

  // Zero wait states: every access phase completes at once
  assign pready  = apbReq.psel & apbReq.penable;
  assign pslverr = pslverrR;
  assign prdata  = prdataR;
  assign setupPh = apbReq.psel & ~apbReq.penable;
  assign wrAcc   = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign wrSlot  = regSlot(apbReq.paddr);
  assign rdSlot  = regSlot(apbReq.paddr);

  // Pins follow the latch and the direction bits
  assign pinOut       = latchR;
  assign pinOe        = dirR;                       // R22
  assign requestFlags = flagR;

  // ****************************************************************
  // Scan sequencer: 8 steps, two channels per step
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      stepR <= `CC_SCAN_FIRST;
    end else if (stepR == `CC_SCAN_LAST) begin
      stepR <= `CC_SCAN_FIRST;                      // R13
    end else begin
      stepR <= stepR + 3'h1;                        // R8
    end
  end

  // ****************************************************************
  // Per-channel event logic
  // ****************************************************************
  for (genvar g = 0; g < 16; g++) begin : gCh
    localparam logic [2:0] SLOT = 3'(g % 8);
    cc_channel_pkg::timer_t tmr;
    logic rise;
    logic fall;
    logic eligible;
    logic once;
    logic hit;
    logic atReload;

    // Channel attaches to the first or second timer
    assign tmr = selR[g] ? timerSecond : timerFirst;  // R4
    // Output latch feeds the detector when the pin is an output
    assign curLvl[g]   = dirR[g] ? latchR[g] : pinIn[g];  // R9 R6
    assign scanned[g]  = (stepR == SLOT);          // R8 R11
    assign fresh[g]    = tmr.inc | tmr.wr;
    assign overflow[g] = tmr.ovf;
    assign capVal[g]   = tmr.count;                 // R1
    assign rise = curLvl[g] & ~lastLvlR[g];
    assign fall = ~curLvl[g] & lastLvlR[g];

    // Edge choice by mode; code 000 does nothing at all
    assign capEv[g] = scanned[g] &
      ((modeR[g] == `CC_MODE_CAP_RISE & rise) |
       (modeR[g] == `CC_MODE_CAP_FALL & fall) |
       (modeR[g] == `CC_MODE_CAP_BOTH & (rise | fall)));  // R2 R3

    // A timer that moves this cycle re-arms the match at once
    assign eligible = ~doneR[g] | fresh[g];          // R12 R14
    assign once = (modeR[g] == `CC_MODE_CMP_ONCE) |
                  (modeR[g] == `CC_MODE_CMP_SET);
    assign atReload = (valueR[g] == tmr.reload);
    assign hit = scanned[g] & isCompare(modeR[g]) &
                 (valueR[g] == tmr.count) & eligible &
                 ~(once & periodDoneR[g] & ~tmr.ovf);  // R10 R18 R20
    assign cmpEv[g] = hit;                          // R15

    // Pin actions; modes 100 and 110 leave the latch alone
    assign hwTog[g] = hit & (modeR[g] == `CC_MODE_CMP_TOGGLE);  // R16
    // Set and clear would coincide at the reload value
    assign hwSet[g] = hit & (modeR[g] == `CC_MODE_CMP_SET) &
                      ~atReload;                    // R19 R21
    assign hwClr[g] = tmr.ovf & (modeR[g] == `CC_MODE_CMP_SET) &
                      ~atReload;                    // R19 R21
  end

  // Pairing enable for each lower/upper channel pair
  for (genvar p = 0; p < 8; p++) begin : gPair
    assign pairedOp[p] = (modeR[p + 8] == `CC_MODE_CMP_MULTI) &
                         (modeR[p] == `CC_MODE_CMP_TOGGLE);  // R24
  end

  // ****************************************************************
  // Channel value registers
  // ****************************************************************

  // A capture beats a same-cycle software write to the value
  always_ff @(posedge clk) begin
    for (int c = 0; c < 16; c++) begin
      if (rst) begin
        valueR[c] <= `CC_RST_VALUE;
      end else if (capEv[c]) begin
        valueR[c] <= capVal[c];                     // R1
      end else if (wrAcc && wrSlot == 5'(c)) begin
        valueR[c] <= apbReq.pwdata[15:0];
      end
    end
  end

  // ****************************************************************
  // Mode, select and direction registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    for (int c = 0; c < 8; c++) begin
      if (rst) begin
        modeR[c]     <= `CC_RST_MODE;
        modeR[c + 8] <= `CC_RST_MODE;
        selR[c]      <= 1'b0;
        selR[c + 8]  <= 1'b0;
      end else if (wrAcc && wrSlot == `CC_SLOT_MODE_LO) begin
        modeR[c] <= apbReq.pwdata[4 * c +: 3];      // R3
        selR[c]  <= apbReq.pwdata[4 * c + 3];
      end else if (wrAcc && wrSlot == `CC_SLOT_MODE_HI) begin
        modeR[c + 8] <= apbReq.pwdata[4 * c +: 3];
        selR[c + 8]  <= apbReq.pwdata[4 * c + 3];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dirR <= `CC_RST_PORT;
    end else if (wrAcc && wrSlot == `CC_SLOT_DIR) begin
      dirR <= apbReq.pwdata[15:0];
    end
  end

  // ****************************************************************
  // Port output latch
  // ****************************************************************

  // Software write takes the whole latch and drops hardware changes
  always_ff @(posedge clk) begin
    if (rst) begin
      latchR <= `CC_RST_PORT;
    end else if (wrAcc && wrSlot == `CC_SLOT_LATCH) begin
      latchR <= apbReq.pwdata[15:0];                // R23 R22
    end else begin
      latchR <= ((latchR ^ hwTog) | hwSet) & ~hwClr;  // R16 R19
    end
  end

  // ****************************************************************
  // Request flags
  // ****************************************************************

  // Sticky; a new event wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      flagR <= `CC_RST_PORT;
    end else begin
      flagR <= (flagR & ~(flagAck |
               ((wrAcc && wrSlot == `CC_SLOT_FLAGS) ?
                apbReq.pwdata[15:0] : `CC_RST_PORT))) |
               capEv | cmpEv;                       // R25 R5 R10
    end
  end

  // ****************************************************************
  // Edge history and match blocking
  // ****************************************************************

  // Sampled once per scan, so short glitches between slots are missed
  always_ff @(posedge clk) begin
    if (rst) begin
      lastLvlR <= `CC_RST_PORT;
    end else begin
      lastLvlR <= (lastLvlR & ~scanned) | (curLvl & scanned);  // R7 R8
    end
  end

  // Blocked from reset: no event until the timer moves or is written
  always_ff @(posedge clk) begin
    if (rst) begin
      doneR <= `CC_RST_DONE;                        // R14
    end else begin
      doneR <= cmpEv | (doneR & ~fresh);            // R12 R13
    end
  end

  // One-shot modes stay blocked for the rest of the timer period
  always_ff @(posedge clk) begin
    if (rst) begin
      periodDoneR <= `CC_RST_PORT;
    end else begin
      for (int c = 0; c < 16; c++) begin
        if (cmpEv[c] && modeR[c][1]) begin
          periodDoneR[c] <= 1'b1;                   // R18 R20
        end else if (overflow[c]) begin
          periodDoneR[c] <= 1'b0;                   // R18 R17
        end
      end
    end
  end

  // ****************************************************************
  // APB read data, captured in the setup cycle
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      prdataR  <= 32'h0000_0000;
      pslverrR <= 1'b0;
    end else if (setupPh) begin
      pslverrR <= (rdSlot == `CC_SLOT_NONE);
      prdataR  <= 32'h0000_0000;
      case (rdSlot)
        `CC_SLOT_MODE_LO: begin
          for (int c = 0; c < 8; c++) begin
            prdataR[4 * c +: 4] <= {selR[c], modeR[c]};
          end
        end
        `CC_SLOT_MODE_HI: begin
          for (int c = 0; c < 8; c++) begin
            prdataR[4 * c +: 4] <= {selR[c + 8], modeR[c + 8]};
          end
        end
        `CC_SLOT_LATCH:  prdataR[15:0] <= latchR;
        `CC_SLOT_DIR:    prdataR[15:0] <= dirR;
        `CC_SLOT_FLAGS:  prdataR[15:0] <= flagR;
        `CC_SLOT_STATUS: prdataR[10:0] <= {stepR, pairedOp};
        `CC_SLOT_NONE:   prdataR <= 32'h0000_0000;
        default:         prdataR[15:0] <= valueR[rdSlot[3:0]];
      endcase
    end
  end

endmodule : capture_compare_channels

`default_nettype wire

/* File: tb/cc_channel_monitor.sv */
// Assertion checker for the capture and compare channel block
`default_nettype none
`include "cc_channel_defs.svh"
module cc_channel_monitor (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     rst,
  // APB slave
  input wire cc_channel_pkg::apb_req_t apbReq,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic [31:0]              prdata,
  // Timers
  input wire cc_channel_pkg::timer_t   timerFirst,
  input wire cc_channel_pkg::timer_t   timerSecond,
  // Pins, flags and pairing
  input wire logic [15:0]              pinIn,
  input wire logic [15:0]              pinOut,
  input wire logic [15:0]              pinOe,
  input wire logic [15:0]              flagAck,
  input wire logic [15:0]              requestFlags,
  input wire logic [7:0]               pairedOp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        acc;
  logic        wrOn;
  logic        wrLatch;
  logic        wrDir;
  logic        wrMode;
  logic [15:0] clrMask;
  // Access phase and the writes that may move outputs
  assign acc     = apbReq.psel & apbReq.penable;
  assign wrOn    = acc & apbReq.pwrite;
  assign wrLatch = wrOn & (apbReq.paddr == `CC_OFF_LATCH);
  assign wrDir   = wrOn & (apbReq.paddr == `CC_OFF_DIR);
  assign wrMode  = wrOn & (apbReq.paddr[7:3] == 5'h08);
  assign clrMask = flagAck | ({16{wrOn & (apbReq.paddr == `CC_OFF_FLAGS)}}
                             & apbReq.pwdata[15:0]);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ************************************************************
  // Assertions; $past guards skip the edge that still sees reset
  // ************************************************************
  sequence setupSeq;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence latchWrSeq;
    setupSeq ##1 wrLatch;
  endsequence
  ready_access_a: assert property (setupSeq ##1 acc |-> pready)
    else $error("pready low in access phase");
  bad_addr_a: assert property (acc && apbReq.paddr[1:0] != 2'h0
    |-> pslverr && prdata == 32'h0) else $error("misaligned not refused");
  latch_sw_wins_a: assert property (
    latchWrSeq |=> pinOut == $past(apbReq.pwdata[15:0]))
    else $error("latch write lost");
  dir_by_write_a: assert property (
    !$past(rst) && pinOe != $past(pinOe) |-> $past(wrDir))
    else $error("direction moved without write");
  latch_cause_a: assert property (
    !$past(rst) && ((pinOut ^ $past(pinOut)) & ~requestFlags) != 16'h0
    |-> $past(wrLatch) || $past(timerFirst.ovf) || $past(timerSecond.ovf))
    else $error("latch moved without cause");
  flag_sticky_a: assert property (!$past(rst) |->
    ($past(requestFlags) & ~requestFlags & ~$past(clrMask)) == 16'h0)
    else $error("flag dropped without clear");
  pair_by_write_a: assert property (
    !$past(rst) && pairedOp != $past(pairedOp) |-> $past(wrMode))
    else $error("pairing moved without mode write");
  pair_status_a: assert property (
    acc && !apbReq.pwrite && apbReq.paddr == `CC_OFF_STATUS
    |-> prdata[7:0] == pairedOp) else $error("status pairing wrong");
endmodule : cc_channel_monitor
`default_nettype wire

/* File: tb/cc_pin_model.sv */
// Sources and loads standing on the channel pins
`default_nettype none
module cc_pin_model (
  // Clock
  input wire logic        clk,
  // Level the bench asks each source to drive
  input wire logic [15:0] extLevel,
  // Block side of the pins
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOe,
  output logic [15:0]     pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] srcLvl_r = 16'h0;
  logic [3:0]  holdCnt_r = 4'h0;
  // A source only moves after holding its level 9 cycles
  always @(posedge clk) begin
    if (holdCnt_r != 4'h8) begin
      holdCnt_r <= holdCnt_r + 4'h1;
    end else if (extLevel != srcLvl_r) begin
      srcLvl_r  <= extLevel;
      holdCnt_r <= 4'h0;
    end
  end
  // Driven pins read back the latch, others the source
  assign pinIn = (pinOe & pinOut) | (~pinOe & srcLvl_r);
endmodule : cc_pin_model
`default_nettype wire

/* File: tb/capture_compare_channels_tb.sv */
// Self-checking bench for the capture and compare channel block
`default_nettype none
module capture_compare_channels_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  cc_channel_pkg::apb_req_t apbReq = '0;
  cc_channel_pkg::timer_t   tf = '{16'h0, 16'h0005, 1'b0, 1'b0, 1'b0};
  cc_channel_pkg::timer_t   ts = '{16'h2222, 16'h0, 1'b0, 1'b0, 1'b0};
  logic [15:0]              extLevel = 16'h0;
  logic [15:0]              flagAck = 16'h0;
  logic [15:0]              pinIn, pinOut, pinOe, requestFlags;
  logic                     pready, pslverr, errSeen;
  logic [31:0]              prdata, rdat;
  logic [7:0]               pairedOp;
  int                       errors = 0;
  int                       checked = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  capture_compare_channels i_capture_compare_channels (
    .clk(clk), .rst(rst), .apbReq(apbReq), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .timerFirst(tf),
    .timerSecond(ts), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .flagAck(flagAck), .requestFlags(requestFlags), .pairedOp(pairedOp));
  cc_pin_model i_cc_pin_model (.clk(clk), .extLevel(extLevel),
    .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));
  // ************************************************************
  // Bus, timer and compare tasks
  // ************************************************************
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    errSeen = pslverr;
    apbReq <= '0;
  endtask : apb
  task automatic chk(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error reg %h expected %h seen %h", a, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(a, e, rdat);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  // Count moves by increment, or by software write when w is set
  task automatic tick(input logic [15:0] v, input logic o, input logic w);
    @(posedge clk);
    tf <= '{v, 16'h0005, ~w, o, w};
    @(posedge clk);
    tf <= '{v, 16'h0005, 1'b0, 1'b0, 1'b0};
  endtask : tick
  task test_done;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // Main sequence; source levels are spaced well past 8 cycles
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(8'h50, 32'h0);
    apb(1'b0, 8'h58, 32'h0);
    chk(8'h58, 32'h1, {31'h0, errSeen});
    rd(8'h41, 32'h0);
    apb(1'b1, 8'h40, 32'h7654_03a1);
    apb(1'b1, 8'h44, 32'h0040_0000);
    apb(1'b1, 8'h4c, 32'h0000_00a0);
    apb(1'b0, 8'h54, 32'h0);
    chk(8'h54, 32'h20, rdat & 32'hff);
    chk(8'h54, 32'h20, {24'h0, pairedOp});
    rd(8'h40, 32'h7654_03a1);
    rd(8'h44, 32'h0040_0000);
    rd(8'h4c, 32'h0000_00a0);
    idle(16);
    rd(8'h50, 32'h0);
    $display("register test done");
    tick(16'h1111, 1'b0, 1'b1);
    extLevel <= 16'h0006;
    idle(20);
    tick(16'h3333, 1'b0, 1'b1);
    extLevel <= 16'h0001;
    idle(20);
    rd(8'h00, 32'h3333);
    rd(8'h04, 32'h2222);
    rd(8'h08, 32'h3333);
    rd(8'h50, 32'h0007);
    flagAck <= 16'h0007;
    idle(1);
    flagAck <= 16'h0;
    rd(8'h50, 32'h0);
    $display("capture test done");
    for (int i = 4; i < 8; i++) begin
      apb(1'b1, 8'(4 * i), 32'h0010);
    end
    tick(16'h0010, 1'b0, 1'b0);
    idle(7);
    rd(8'h50, 32'h00f0);
    rd(8'h48, 32'h00a0);
    apb(1'b1, 8'h50, 32'h00ff);
    idle(16);
    rd(8'h50, 32'h0);
    for (int i = 4; i < 8; i++) begin
      apb(1'b1, 8'(4 * i), (i == 5) ? 32'h0030 : 32'h0020);
    end
    tick(16'h0020, 1'b0, 1'b0);
    idle(7);
    rd(8'h50, 32'h0010);
    rd(8'h48, 32'h00a0);
    $display("compare test done");
    tick(16'h0005, 1'b1, 1'b0);
    idle(7);
    rd(8'h48, 32'h0020);
    apb(1'b1, 8'h50, 32'h00ff);
    tick(16'h0020, 1'b0, 1'b0);
    idle(7);
    rd(8'h50, 32'h00d0);
    rd(8'h48, 32'h00a0);
    apb(1'b1, 8'h1c, 32'h0005);
    apb(1'b1, 8'h50, 32'h00ff);
    tick(16'h0005, 1'b1, 1'b0);
    idle(7);
    rd(8'h50, 32'h0080);
    rd(8'h48, 32'h00a0);
    chk(8'h48, 32'h00a0, {16'h0, pinOut});
    $display("overflow test done");
    apb(1'b1, 8'h50, 32'h00ff);
    apb(1'b1, 8'h4c, 32'h00a1);
    idle(10);
    chk(8'h4c, 32'h00a1, {16'h0, pinOe});
    apb(1'b1, 8'h48, 32'h00a1);
    idle(10);
    rd(8'h00, 32'h0005);
    rd(8'h50, 32'h0001);
    chk(8'h50, 32'h0001, {16'h0, requestFlags});
    $display("latch capture test done");
    // Overflow would clear bit 7 at the very edge the latch write lands
    apb(1'b1, 8'h1c, 32'h0040);
    fork
      apb(1'b1, 8'h48, 32'h00a1);
      begin
        repeat (2) @(posedge clk);
        tf <= '{16'h0005, 16'h0005, 1'b1, 1'b1, 1'b0};
        @(posedge clk);
        tf <= '{16'h0005, 16'h0005, 1'b0, 1'b0, 1'b0};
      end
    join
    rd(8'h48, 32'h00a1);
    $display("latch priority test done");
    test_done;
  end
  // Watchdog well beyond the few hundred cycles of the tests
  initial begin
    #100000;
    errors++;
    test_done;
  end
endmodule : capture_compare_channels_tb
bind capture_compare_channels cc_channel_monitor i_cc_channel_monitor (
  .clk(clk), .rst(rst), .apbReq(apbReq), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .timerFirst(timerFirst),
  .timerSecond(timerSecond), .pinIn(pinIn), .pinOut(pinOut),
  .pinOe(pinOe), .flagAck(flagAck), .requestFlags(requestFlags),
  .pairedOp(pairedOp));
`default_nettype wire
